//--- src/sssp_pkg.sv
package sssp_pkg;
   localparam int DataWidth = 8;
   localparam logic [3:0] ModeSlaveSelect = 4'h4;
   localparam logic [3:0] ModeSlaveNoSelect = 4'h5;
   localparam logic [3:0] ModeMasterDiv4 = 4'h0;
   // Field positions in serial_control_first.
   localparam int PosCollision = 7;
   localparam int PosOverflow = 6;
   localparam int PosEnable = 5;
   localparam int PosIdlePol = 4;
   // Field positions in serial_port_state; PosOverwrite indexes the separate overwriteEnable input.
   localparam int PosSamplePhase = 7;
   localparam int PosClockEdge = 6;
   localparam int PosBufferFull = 0;
   localparam int PosOverwrite = 4;
   localparam logic [7:0] ControlReset = 8'h00;
   localparam logic [7:0] StateReset = 8'h00;
   localparam int MasterHalfDiv = 4;
endpackage

//--- src/sssp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sssp_link_if;
   logic serialClk;
   logic selectN;
   logic masterData;
   logic slaveData;
   logic slaveDataOe;
   modport device (input serialClk, input selectN, input masterData, output slaveData, output slaveDataOe);
   modport master (output serialClk, output selectN, output masterData, input slaveData, input slaveDataOe);
endinterface
`default_nettype wire

//--- src/sssp_device.sv
`timescale 1ns/1ps
`default_nettype none
module sssp_device (
   input wire logic refClk,
   input wire logic resetn,
   sssp_link_if.device link,
   input wire logic sleepMode,
   input wire logic portIntEnable,
   input wire logic ctlWrite,
   input wire logic [7:0] ctlWdata,
   input wire logic stateWrite,
   input wire logic [7:0] stateWdata,
   input wire logic [7:0] overwriteEnable,
   input wire logic bufWrite,
   input wire logic [7:0] bufWdata,
   input wire logic bufRead,
   output logic [7:0] bufRdata,
   output logic [7:0] ctlRdata,
   output logic [7:0] stateRdata,
   output logic portIntFlag,
   output logic wakeReq,
   input wire logic intFlagClear
);
   logic [7:0] ctl_ff;
   logic [1:0] smpCfg_ff;
   logic [7:0] rxBuf_ff;
   logic [7:0] shift_ff;
   logic [2:0] bitCnt_ff;
   logic bufFull_ff;
   logic intFlag_ff;
   logic wake_ff;
   logic dout_ff;
   logic doutOe_ff;
   logic [2:0] sckSync_ff;
   logic [2:0] ssSync_ff;
   logic [1:0] mosiSync_ff;
   logic busy_ff;
   logic [7:0] nxt_shift;
   wire [3:0] mode = ctl_ff[3:0];
   wire enable = ctl_ff[sssp_pkg::PosEnable];
   wire selMode = (mode == sssp_pkg::ModeSlaveSelect);
   wire slaveMode = selMode || (mode == sssp_pkg::ModeSlaveNoSelect);
   wire ssLow = !ssSync_ff[1];
   wire ssFall = ssSync_ff[2] && !ssSync_ff[1];
   wire portReset = !enable || (selMode && !ssLow);
   wire active = slaveMode && enable && (!selMode || ssLow);
   wire idlePol = ctl_ff[sssp_pkg::PosIdlePol];
   wire edgeSel = smpCfg_ff[0];
   wire sckRise = sckSync_ff[1] && !sckSync_ff[2];
   wire sckFall = !sckSync_ff[1] && sckSync_ff[2];
   wire sampleEdge = (idlePol ^ edgeSel) ? sckFall : sckRise;
   wire shiftEdge = (idlePol ^ edgeSel) ? sckRise : sckFall;
   wire doSample = active && sampleEdge;
   wire byteDone = doSample && (bitCnt_ff == 3'h7);
   wire wrCollide = bufWrite && busy_ff;
   wire wrOk = bufWrite && !busy_ff && !ctl_ff[sssp_pkg::PosCollision];
   wire overflow = byteDone && bufFull_ff && !overwriteEnable[sssp_pkg::PosOverwrite];
   // A select edge while the port is held in reset must not start a frame.
   wire frameStart = ssFall && selMode && !portReset;
   wire driveNext = frameStart || (active && shiftEdge);
   wire [7:0] ctlBase = ctlWrite ? ctlWdata : ctl_ff;
   wire [7:0] ctlSetBits = {wrCollide, overflow, 6'h00};
   wire nxtBusy = (bitCnt_ff != 3'h7);
   wire nxtWake = sleepMode && portIntEnable && (intFlag_ff || byteDone);
   assign nxt_shift = {shift_ff[6:0], mosiSync_ff[1]};
   assign ctlRdata = ctl_ff;
   assign stateRdata = {smpCfg_ff, 5'h00, bufFull_ff};
   assign bufRdata = rxBuf_ff;
   assign portIntFlag = intFlag_ff;
   assign wakeReq = wake_ff;
   assign link.slaveData = dout_ff;
   assign link.slaveDataOe = doutOe_ff;
   // Serial clock and select are sampled three times, data twice; sleep does not gate the slave path.
   always_ff @(posedge refClk or negedge resetn)
   begin
      if (!resetn)
         sckSync_ff <= 3'h0;
      else
         sckSync_ff <= {sckSync_ff[1:0], link.serialClk};
   end
   always_ff @(posedge refClk or negedge resetn)
   begin
      if (!resetn)
         ssSync_ff <= 3'h7;
      else
         ssSync_ff <= {ssSync_ff[1:0], link.selectN};
   end
   always_ff @(posedge refClk or negedge resetn)
   begin
      if (!resetn)
         mosiSync_ff <= 2'h0;
      else
         mosiSync_ff <= {mosiSync_ff[0], link.masterData};
   end
   // A hardware event sets its flag even when software writes the register in the same cycle.
   always_ff @(posedge refClk or negedge resetn)
   begin
      if (!resetn)
         ctl_ff <= sssp_pkg::ControlReset;
      else
         ctl_ff <= ctlBase | ctlSetBits;
   end
   always_ff @(posedge refClk or negedge resetn)
   begin
      if (!resetn)
         smpCfg_ff <= 2'h0;
      else if (stateWrite)
         smpCfg_ff <= stateWdata[7:6];
   end
   always_ff @(posedge refClk or negedge resetn)
   begin
      if (!resetn)
         doutOe_ff <= 1'b0;
      else
         doutOe_ff <= active;
   end
   always_ff @(posedge refClk or negedge resetn)
   begin
      if (!resetn)
         bitCnt_ff <= 3'h0;
      else if (portReset || frameStart)
         bitCnt_ff <= 3'h0;
      else if (doSample)
         bitCnt_ff <= bitCnt_ff + 3'h1;
   end
   always_ff @(posedge refClk or negedge resetn)
   begin
      if (!resetn)
         busy_ff <= 1'b0;
      else if (portReset)
         busy_ff <= 1'b0;
      else if (doSample)
         busy_ff <= nxtBusy;
   end
   // The buffer may be loaded while the select is high, so the port reset does not block it.
   always_ff @(posedge refClk or negedge resetn)
   begin
      if (!resetn)
         shift_ff <= 8'h00;
      else if (wrOk)
         shift_ff <= bufWdata;
      else if (doSample)
         shift_ff <= nxt_shift;
   end
   always_ff @(posedge refClk or negedge resetn)
   begin
      if (!resetn)
         dout_ff <= 1'b0;
      else if (wrOk)
         dout_ff <= bufWdata[7];
      else if (driveNext)
         dout_ff <= shift_ff[7];
   end
   always_ff @(posedge refClk or negedge resetn)
   begin
      if (!resetn)
         rxBuf_ff <= 8'h00;
      else if (byteDone && !overflow)
         rxBuf_ff <= nxt_shift;
   end
   always_ff @(posedge refClk or negedge resetn)
   begin
      if (!resetn)
         bufFull_ff <= 1'b0;
      else if (byteDone)
         bufFull_ff <= 1'b1;
      else if (bufRead)
         bufFull_ff <= 1'b0;
   end
   always_ff @(posedge refClk or negedge resetn)
   begin
      if (!resetn)
         intFlag_ff <= 1'b0;
      else if (byteDone)
         intFlag_ff <= 1'b1;
      else if (intFlagClear)
         intFlag_ff <= 1'b0;
   end
   always_ff @(posedge refClk or negedge resetn)
   begin
      if (!resetn)
         wake_ff <= 1'b0;
      else
         wake_ff <= nxtWake;
   end
endmodule
`default_nettype wire

//--- src/sssp_master.sv
`timescale 1ns/1ps
`default_nettype none
module sssp_master (
   input wire logic refClk,
   input wire logic resetn,
   sssp_link_if.master link,
   input wire logic sleepMode,
   input wire logic start,
   input wire logic [7:0] txData,
   output logic [7:0] rxData,
   output logic done,
   output logic busy
);
   typedef enum logic [1:0] {SsspIdle, SsspLow, SsspHigh, SsspEnd} sssp_state_e;
   sssp_state_e state_ff;
   logic [7:0] shift_ff;
   logic [3:0] cnt_ff;
   logic [7:0] div_ff;
   logic sck_ff;
   logic ss_ff;
   logic done_ff;
   logic [1:0] misoSync_ff;
   wire tick = !sleepMode && (div_ff == 8'(sssp_pkg::MasterHalfDiv - 1));
   assign link.serialClk = sck_ff;
   assign link.selectN = ss_ff;
   assign link.masterData = shift_ff[7];
   assign rxData = shift_ff;
   assign done = done_ff;
   assign busy = (state_ff != SsspIdle);
   always_ff @(posedge refClk or negedge resetn)
   begin
      if (!resetn)
         misoSync_ff <= 2'h0;
      else
         misoSync_ff <= {misoSync_ff[0], link.slaveData && link.slaveDataOe};
   end
   always_ff @(posedge refClk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_ff <= SsspIdle;
         shift_ff <= 8'h00;
         cnt_ff <= 4'h0;
         div_ff <= 8'h00;
         sck_ff <= 1'b0;
         ss_ff <= 1'b1;
         done_ff <= 1'b0;
      end
      else
      begin
         done_ff <= 1'b0;
         if (!sleepMode)
            div_ff <= tick ? 8'h00 : div_ff + 8'h01;
         unique case (state_ff)
            SsspIdle:
               if (start)
               begin
                  shift_ff <= txData;
                  ss_ff <= 1'b0;
                  cnt_ff <= 4'h0;
                  state_ff <= SsspLow;
               end
            SsspLow:
               if (tick)
               begin
                  sck_ff <= 1'b1;
                  state_ff <= SsspHigh;
               end
            SsspHigh:
               if (tick)
               begin
                  sck_ff <= 1'b0;
                  shift_ff <= {shift_ff[6:0], misoSync_ff[1]};
                  cnt_ff <= cnt_ff + 4'h1;
                  state_ff <= (cnt_ff == 4'h7) ? SsspEnd : SsspLow;
               end
            SsspEnd:
               if (tick)
               begin
                  ss_ff <= 1'b1;
                  done_ff <= 1'b1;
                  state_ff <= SsspIdle;
               end
         endcase
      end
   end
endmodule
`default_nettype wire

//--- sim/sssp_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sssp_link_checker (
   input wire logic refClk,
   input wire logic resetn,
   input wire logic serialClk,
   input wire logic selectN,
   input wire logic masterData,
   input wire logic slaveData,
   input wire logic slaveDataOe
);
   default clocking @(posedge refClk);
   endclocking
   default disable iff (!resetn);
   idle_float_a: assert property (selectN [*6] |-> !slaveDataOe)
      else $error("data out driven while idle");
   select_drive_a: assert property (!selectN [*6] |-> slaveDataOe)
      else $error("data out not driven while selected");
   release_float_a: assert property ($rose(selectN) |-> ##[0:6] !slaveDataOe)
      else $error("data out kept after deselect");
   idle_clock_a: assert property (selectN [*3] |-> $stable(serialClk))
      else $error("serial clock moves while idle");
   frame_hold_a: assert property ($fell(selectN) |=> !selectN [*8])
      else $error("select pulse too short");
   half_period_a: assert property (!selectN && $changed(serialClk) |=> $stable(serialClk) [*3])
      else $error("serial clock half period wrong");
   master_bit_a: assert property ($rose(serialClk) |-> $stable(masterData))
      else $error("master data moves at sample edge");
   slave_bit_a: assert property ($rose(serialClk) && slaveDataOe |-> $stable(slaveData))
      else $error("slave data moves at sample edge");
endmodule
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic refClk = 1'b0;
   logic resetn = 1'b0;
   logic dSleep = 1'b0, mSleep = 1'b0, intEn = 1'b1, ctlWrite = 1'b0, bufWrite = 1'b0;
   logic bufRead = 1'b0, intClr = 1'b0, start = 1'b0, intFlag, wake, done, busy;
   logic [7:0] ctlWdata = 8'h00, bufWdata = 8'h00, txData = 8'h00;
   logic [7:0] bufRdata, ctlRdata, stateRdata, rxData;
   logic c;
   int fails = 0, total_checks = 0, cyc = 0;
   always #2.5 refClk = ~refClk;
   sssp_link_if linkIf ();
   sssp_device u_sssp_device (.refClk(refClk), .resetn(resetn), .link(linkIf), .sleepMode(dSleep),
      .portIntEnable(intEn), .ctlWrite(ctlWrite), .ctlWdata(ctlWdata), .stateWrite(1'b0),
      .stateWdata(8'h00), .overwriteEnable(8'h00), .bufWrite(bufWrite), .bufWdata(bufWdata),
      .bufRead(bufRead), .bufRdata(bufRdata), .ctlRdata(ctlRdata), .stateRdata(stateRdata),
      .portIntFlag(intFlag), .wakeReq(wake), .intFlagClear(intClr));
   sssp_master u_sssp_master (.refClk(refClk), .resetn(resetn), .link(linkIf), .sleepMode(mSleep),
      .start(start), .txData(txData), .rxData(rxData), .done(done), .busy(busy));
   sssp_link_checker u_sssp_link_checker (.refClk(refClk), .resetn(resetn), .serialClk(linkIf.serialClk),
      .selectN(linkIf.selectN), .masterData(linkIf.masterData), .slaveData(linkIf.slaveData),
      .slaveDataOe(linkIf.slaveDataOe));
   task give_verdict;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task cfg(input logic [7:0] d);
      @(negedge refClk) ctlWrite = 1'b1;
      ctlWdata = d;
      @(negedge refClk) ctlWrite = 1'b0;
   endtask
   task ld(input logic [7:0] d);
      @(negedge refClk) bufWrite = 1'b1;
      bufRead = 1'b1;
      bufWdata = d;
      @(negedge refClk) bufWrite = 1'b0;
      bufRead = 1'b0;
   endtask
   task xfer(input logic [7:0] tx, input logic [7:0] exp);
      int n;
      @(negedge refClk) start = 1'b1;
      txData = tx;
      @(negedge refClk) start = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 400)
      begin
         @(negedge refClk);
         n++;
      end
      chk(rxData, exp);
      repeat (8) @(negedge refClk);
   endtask
   task t_sleep_rx;
      ld(8'h3C);
      dSleep = 1'b1;
      xfer(8'hA5, 8'h3C);
      chk(bufRdata, 8'hA5);
      chk({7'h00, stateRdata[0]}, 8'h01);
      chk({6'h00, intFlag, wake}, 8'h03);
      intClr = 1'b1;
      intEn = 1'b0;
      @(negedge refClk) intClr = 1'b0;
      dSleep = 1'b0;
   endtask
   task t_collision;
      ld(8'h81);
      fork
         xfer(8'h5A, 8'h81);
         begin
            repeat (20) @(negedge refClk);
            ld(8'hFF);
         end
      join
      chk({7'h00, ctlRdata[7]}, 8'h01);
      cfg(8'h24);
      chk(ctlRdata, 8'h24);
   endtask
   task t_master_sleep;
      ld(8'h66);
      fork
         xfer(8'hC3, 8'h66);
         begin
            repeat (30) @(negedge refClk);
            mSleep = 1'b1;
            c = linkIf.serialClk;
            repeat (40) @(negedge refClk);
            chk({7'h00, linkIf.serialClk}, {7'h00, c});
            mSleep = 1'b0;
         end
      join
      chk(bufRdata, 8'hC3);
   endtask
   always @(posedge refClk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         give_verdict;
      end
   end
   initial
   begin
      repeat (5) @(negedge refClk);
      resetn = 1'b1;
      repeat (2) @(negedge refClk);
      cfg(8'h24);
      chk(ctlRdata, 8'h24);
      t_sleep_rx;
      t_collision;
      t_master_sleep;
      give_verdict;
   end
endmodule
`default_nettype wire
